// ### cwt_pkg.sv
// package: register map, field layout, reset values and timing counts of the wake timer block
package cwt_pkg;

  // ==========================================
  // register addresses and read masks
  localparam logic [6:0] ADDR_TIMER = 7'h06;
  localparam logic [6:0] ADDR_MASK = 7'h09;
  localparam logic [15:0] TIMER_RST = 16'h0000;
  localparam logic [15:0] MASK_RST = 16'h0140;
  localparam logic [15:0] TIMER_RMASK = 16'hEF77 | 16'h0080;
  localparam logic [15:0] MASK_RMASK = 16'h01FF;

  // ==========================================
  // field positions
  localparam int T2ON_LSB = 13;
  localparam int T2PER_LSB = 9;
  localparam int SEL_LSB = 7;
  localparam int T1ON_LSB = 4;
  localparam int T1PER_LSB = 0;
  localparam int B_PERIODIC = 8;
  localparam int B_WDOFF = 7;
  localparam int B_WDIRQ = 6;
  localparam int B_SERIAL = 5;
  localparam int B_BRIDGE = 4;
  localparam int B_TEMP = 1;
  localparam int B_SUPPLY = 0;

  // ==========================================
  // cyclic wake selector codes
  localparam logic [1:0] SEL_OFF = 2'h0;
  localparam logic [1:0] SEL_T1 = 2'h1;
  localparam logic [1:0] SEL_T2 = 2'h2;
  localparam logic [2:0] FILT_T1 = 3'h2;
  localparam logic [2:0] FILT_T2 = 3'h3;

  // ==========================================
  // timing
  localparam int CLK_NS = 10;
  localparam int TICK_NS = 100000;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  localparam int FILT_NS = 16000;
  localparam int FILT_CYCLES = FILT_NS / CLK_NS;
  localparam int IRQ_PULSE_NS = 1000;
  localparam int IRQ_PULSE_CYCLES = IRQ_PULSE_NS / CLK_NS;
  localparam int IRQ_REPEAT_MS = 10;
  localparam int IRQ_REPEAT_TICKS = IRQ_REPEAT_MS * 1000000 / TICK_NS;
  localparam int ON_US [8] = '{0, 100, 300, 1000, 10000, 20000, 0, 0};
  localparam int PER_MS [8] = '{10, 20, 50, 100, 200, 500, 1000, 2000};

  // on-time in ticks, zero means off or reserved
  function automatic logic [15:0] on_ticks(input logic [2:0] code);
    return 16'(ON_US[code] * 1000 / TICK_NS); // R1 R3
  endfunction : on_ticks

  // period in ticks
  function automatic logic [15:0] per_ticks(input logic [2:0] code);
    return 16'(PER_MS[code] * (1000000 / TICK_NS)); // R2 R4
  endfunction : per_ticks

endpackage : cwt_pkg

// ### cwt_timer_if.sv
// interface: one wake timer's settings and events between controller and timer
`timescale 1ns/1ns
interface cwt_timer_if;
  logic armed;
  logic [2:0] on_code;
  logic [2:0] per_code;
  logic tick;
  logic active;
  logic wake;
  logic sample;
  modport ctrl (output armed, on_code, per_code, tick, input active, wake, sample);
  modport timer (input armed, on_code, per_code, tick, output active, wake, sample);
endinterface : cwt_timer_if

// ### cwt_timer.sv
// module: one cyclic wake timer with on-time and period
`timescale 1ns/1ns
module cwt_timer (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // settings and events
  cwt_timer_if.timer tif
);
  typedef enum logic [1:0] {TS_IDLE, TS_ON, TS_OFF} cwt_tstate_t;
  cwt_tstate_t state;
  logic [15:0] cnt;
  logic [15:0] on_t;
  logic [15:0] on_lat;
  logic [15:0] per_t;
  logic [15:0] cnt_inc;

  assign on_t = cwt_pkg::on_ticks(tif.on_code);
  assign per_t = cwt_pkg::per_ticks(tif.per_code);
  assign cnt_inc = cnt + 16'h0001;

  // ==========================================
  // period sequencer
  always_ff @(posedge clk_sys) begin
    tif.wake <= 1'b0;
    tif.sample <= 1'b0;
    if (srst || !tif.armed) begin
      state <= TS_IDLE;
      cnt <= 16'h0000;
    end else begin
      case (state)
        TS_IDLE: begin
          state <= TS_ON;
          cnt <= 16'h0000;
          on_lat <= on_t;
          tif.wake <= 1'b1; // R21
        end
        TS_ON, TS_OFF: begin
          if (tif.tick) begin
            if (cnt_inc >= per_t) begin
              state <= TS_ON;
              cnt <= 16'h0000;
              on_lat <= on_t;
              tif.wake <= 1'b1; // R21
              tif.sample <= (state == TS_ON);
            end else begin
              cnt <= cnt_inc;
              if (state == TS_ON && cnt_inc >= on_lat) begin
                state <= TS_OFF;
                tif.sample <= 1'b1; // R20
              end
            end
          end
        end
        default: state <= TS_IDLE;
      endcase
    end
  end

  assign tif.active = (state == TS_ON);

  chk_wake_starts_on: assert property (@(posedge clk_sys) disable iff (srst) // R21
    tif.wake |-> state == TS_ON && cnt == 16'h0000) else $error("wake without on phase");
  chk_on_bound: assert property (@(posedge clk_sys) disable iff (srst) // R21
    state == TS_ON |-> cnt < on_lat || !tif.armed) else $error("on phase too long");
endmodule : cwt_timer

// ### cwt_wake_filter.sv
// module: wake input filter opened at the end of a timer on-time
`timescale 1ns/1ns
module cwt_wake_filter #(
  parameter int FILT_CYCLES = cwt_pkg::FILT_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // sampling
  input wire logic start,
  input wire logic wake_in,
  output logic hit
);
  logic [15:0] cnt;
  logic busy;

  if (FILT_CYCLES < 1 || FILT_CYCLES > 65535) begin : g_bad
    $error("filter length out of range");
  end

  // ==========================================
  // window: input must stay high for the whole filter time
  always_ff @(posedge clk_sys) begin
    hit <= 1'b0;
    if (srst) begin
      busy <= 1'b0;
      cnt <= 16'h0000;
    end else if (start) begin
      busy <= wake_in;
      cnt <= 16'h0001;
    end else if (busy) begin
      if (!wake_in) begin
        busy <= 1'b0;
      end else if (cnt >= 16'(FILT_CYCLES)) begin
        busy <= 1'b0;
        hit <= 1'b1; // R20
      end else begin
        cnt <= cnt + 16'h0001;
      end
    end
  end

  chk_filter_high: assert property (@(posedge clk_sys) disable iff (srst) // R20
    hit |-> $past(wake_in, 1) && $past(busy, 1)) else $error("filter hit on low input");
endmodule : cwt_wake_filter

// ### cwt_ctrl.sv
// module: wake timer control and interrupt mask registers with interrupt pin logic
// How it works
// R1: timer two on-time codes off to 20 ms
// R2: timer two period codes 10 ms to 2 s
// R3: timer one on-time uses same encoding
// R4: timer one period codes 10 ms to 2 s
// R5: selector 00 none, 01 timer one, 10 two
// R6: timer arms when assigned, then on-time set
// R7: reserved bits read back as zero
// R8: timer register clears on every reset kind
// R9: bit 8 repeats interrupt while events pending
// R10: bit 7 stops development mode watchdog
// R11: bit 6 passes watchdog failure interrupt
// R12: bit 5 passes frame and checksum errors
// R13: bit 4 passes bridge status interrupt
// R14: controller writes zero to bits 3:2
// R15: enabled events pulse interrupt pin low
// R16: repeated event pulses again while flag set
// R17: bit 1 passes temperature status interrupt
// R18: bit 0 passes supply status interrupt
// R19: mask resets to 0x0140, restart keeps it
// R20: cyclic filter samples at on-time end
// R21: one wake per period, on-time first
// R22: device updates timer fields, reads current
// R23: registers reached by seven-bit frame address
`timescale 1ns/1ns
module cwt_ctrl #(
  parameter int TICK_CYCLES = cwt_pkg::TICK_CYCLES,
  parameter int FILT_CYCLES = cwt_pkg::FILT_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // register access from decoded serial frames
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rd_valid,
  // reset kinds beyond power-on
  input wire logic soft_rst,
  input wire logic restart,
  // device-side timer update
  input wire logic hw_timer_load,
  input wire logic [15:0] hw_timer_value,
  // event sources
  input wire logic wd_fail_devmode,
  input wire logic spi_fail,
  input wire logic crc_fail,
  input wire logic bridge_stat_set,
  input wire logic temp_stat_set,
  input wire logic supply_stat_set,
  input wire logic irq_pending,
  input wire logic devmode,
  // wake input
  input wire logic [2:0] wake_input_filter_select,
  input wire logic wake_in,
  // outputs
  output logic irq_out_n,
  output logic wake_event,
  output logic wake_hit,
  output logic [1:0] timer_active,
  output logic watchdog_run
);
  logic [15:0] wake_timer_control;
  logic [15:0] interrupt_enable_mask;
  logic [15:0] next_timer;
  logic timer_upd;
  logic [1:0] armed;
  logic [1:0] t_wake;
  logic [1:0] t_sample;
  logic [1:0] t_active;
  logic [15:0] div_cnt;
  logic tick;
  logic [7:0] pulse_cnt;
  logic [15:0] rep_cnt;
  logic rep_fire;
  logic event_any;
  logic filt_start;
  logic [1:0] cyclic_wake_select;
  logic any_reset;

  if (TICK_CYCLES < 2 || TICK_CYCLES > 65535) begin : g_bad_tick
    $error("tick divider out of range");
  end

  assign any_reset = srst || soft_rst;
  assign cyclic_wake_select = wake_timer_control[cwt_pkg::SEL_LSB +: 2];

  // ==========================================
  // timer control register
  always_comb begin
    timer_upd = 1'b0;
    next_timer = wake_timer_control;
    if (reg_wr && reg_addr == cwt_pkg::ADDR_TIMER) begin
      timer_upd = 1'b1;
      next_timer = reg_wdata & cwt_pkg::TIMER_RMASK; // R7 R23
    end else if (hw_timer_load) begin
      timer_upd = 1'b1;
      next_timer = hw_timer_value & cwt_pkg::TIMER_RMASK; // R22
    end
  end

  always_ff @(posedge clk_sys) begin
    if (any_reset || restart) begin
      wake_timer_control <= cwt_pkg::TIMER_RST; // R8
    end else if (timer_upd) begin
      wake_timer_control <= next_timer; // R22
    end
  end

  // ==========================================
  // interrupt mask register
  always_ff @(posedge clk_sys) begin
    if (any_reset) begin
      interrupt_enable_mask <= cwt_pkg::MASK_RST; // R19
    end else if (reg_wr && reg_addr == cwt_pkg::ADDR_MASK) begin
      interrupt_enable_mask <= reg_wdata & cwt_pkg::MASK_RMASK; // R7 R14
    end
  end

  // ==========================================
  // read port
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= 16'h0000;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          cwt_pkg::ADDR_TIMER: reg_rdata <= wake_timer_control; // R22 R23
          cwt_pkg::ADDR_MASK: reg_rdata <= interrupt_enable_mask; // R23
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // ==========================================
  // 100 us tick divider
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      div_cnt <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= (div_cnt == 16'(TICK_CYCLES - 1));
      if (div_cnt == 16'(TICK_CYCLES - 1)) begin
        div_cnt <= 16'h0000;
      end else begin
        div_cnt <= div_cnt + 16'h0001;
      end
    end
  end

  // ==========================================
  // timers
  for (genvar i = 0; i < 2; i++) begin : g_timer
    localparam logic [1:0] MY_SEL = (i == 0) ? cwt_pkg::SEL_T1 : cwt_pkg::SEL_T2;
    localparam int ON_LSB = (i == 0) ? cwt_pkg::T1ON_LSB : cwt_pkg::T2ON_LSB;
    localparam int PER_LSB = (i == 0) ? cwt_pkg::T1PER_LSB : cwt_pkg::T2PER_LSB;
    cwt_timer_if tif ();

    // arm only when already assigned and then given an on-time
    always_ff @(posedge clk_sys) begin
      if (any_reset || restart) begin
        armed[i] <= 1'b0;
      end else if (timer_upd) begin
        if (next_timer[cwt_pkg::SEL_LSB +: 2] != MY_SEL || cwt_pkg::on_ticks(next_timer[ON_LSB +: 3]) == 16'h0000) begin
          armed[i] <= 1'b0; // R5 R6
        end else if (cyclic_wake_select == MY_SEL) begin
          armed[i] <= 1'b1; // R6
        end
      end
    end

    assign tif.armed = armed[i];
    assign tif.on_code = wake_timer_control[ON_LSB +: 3]; // R1 R3
    assign tif.per_code = wake_timer_control[PER_LSB +: 3]; // R2 R4
    assign tif.tick = tick;
    assign t_wake[i] = tif.wake;
    assign t_sample[i] = tif.sample;
    assign t_active[i] = tif.active;

    cwt_timer u_timer (
      .clk_sys(clk_sys),
      .srst(srst),
      .tif(tif)
    );

    chk_armed_needs_sel: assert property (@(posedge clk_sys) disable iff (srst) // R6
      armed[i] |-> cyclic_wake_select == MY_SEL && wake_timer_control[ON_LSB +: 3] != 3'h0)
      else $error("timer armed without assignment");
  end

  // ==========================================
  // wake outputs and cyclic filter
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wake_event <= 1'b0;
      timer_active <= 2'h0;
    end else begin
      wake_event <= |(t_wake & armed); // R5 R21
      timer_active <= t_active;
    end
  end

  assign filt_start = (wake_input_filter_select == cwt_pkg::FILT_T1 && t_sample[0])
    || (wake_input_filter_select == cwt_pkg::FILT_T2 && t_sample[1]); // R20

  cwt_wake_filter #(
    .FILT_CYCLES(FILT_CYCLES)
  ) u_filter (
    .clk_sys(clk_sys),
    .srst(srst),
    .start(filt_start),
    .wake_in(wake_in),
    .hit(wake_hit)
  );

  // ==========================================
  // watchdog control in development mode
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      watchdog_run <= 1'b1;
    end else begin
      watchdog_run <= !(devmode && interrupt_enable_mask[cwt_pkg::B_WDOFF]); // R10
    end
  end

  // ==========================================
  // interrupt pin
  assign event_any = (wd_fail_devmode && interrupt_enable_mask[cwt_pkg::B_WDIRQ]) // R11
    || ((spi_fail || crc_fail) && interrupt_enable_mask[cwt_pkg::B_SERIAL]) // R12
    || (bridge_stat_set && interrupt_enable_mask[cwt_pkg::B_BRIDGE]) // R13
    || (temp_stat_set && interrupt_enable_mask[cwt_pkg::B_TEMP]) // R17
    || (supply_stat_set && interrupt_enable_mask[cwt_pkg::B_SUPPLY]); // R18

  assign rep_fire = tick && rep_cnt >= 16'(cwt_pkg::IRQ_REPEAT_TICKS - 1);

  always_ff @(posedge clk_sys) begin
    if (srst || !interrupt_enable_mask[cwt_pkg::B_PERIODIC] || !irq_pending || event_any) begin
      rep_cnt <= 16'h0000;
    end else if (tick) begin
      rep_cnt <= rep_fire ? 16'h0000 : rep_cnt + 16'h0001; // R9
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pulse_cnt <= 8'h00;
      irq_out_n <= 1'b1;
    end else if (event_any || (rep_fire && irq_pending && interrupt_enable_mask[cwt_pkg::B_PERIODIC])) begin
      pulse_cnt <= 8'(cwt_pkg::IRQ_PULSE_CYCLES - 1); // R15 R16 R9
      irq_out_n <= 1'b0;
    end else if (pulse_cnt != 8'h00) begin
      pulse_cnt <= pulse_cnt - 8'h01;
    end else begin
      irq_out_n <= 1'b1;
    end
  end

  // ==========================================
  // checks
  sequence s_timer_read;
    reg_rd && reg_addr == cwt_pkg::ADDR_TIMER ##1 reg_rd_valid;
  endsequence
  sequence s_quiet;
    !event_any && !rep_fire && pulse_cnt == 8'h00;
  endsequence

  chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (srst) // R7
    s_timer_read |-> reg_rdata[12] == 1'b0 && reg_rdata[3] == 1'b0) else $error("reserved bit set");
  chk_mask_reset: assert property (@(posedge clk_sys) // R19
    srst |=> interrupt_enable_mask == 16'h0140) else $error("mask reset value wrong");
  chk_restart_clear: assert property (@(posedge clk_sys) disable iff (srst) // R8
    restart |=> wake_timer_control == 16'h0000 && armed == 2'h0) else $error("restart left timer set");
  chk_restart_keep: assert property (@(posedge clk_sys) disable iff (srst) // R19
    restart && !soft_rst && !reg_wr |=> $stable(interrupt_enable_mask)) else $error("restart changed mask");
  chk_event_pulse: assert property (@(posedge clk_sys) disable iff (srst) // R15 R16
    event_any |=> !irq_out_n [*2]) else $error("event did not pulse pin");
  chk_quiet_high: assert property (@(posedge clk_sys) disable iff (srst) // R15
    s_quiet |=> irq_out_n) else $error("pin low without cause");
  chk_repeat_gated: assert property (@(posedge clk_sys) disable iff (srst) // R9
    !interrupt_enable_mask[cwt_pkg::B_PERIODIC] |=> rep_cnt == 16'h0000) else $error("repeat while off");
  chk_wd_control: assert property (@(posedge clk_sys) disable iff (srst) // R10
    devmode && interrupt_enable_mask[cwt_pkg::B_WDOFF] |=> !watchdog_run) else $error("watchdog not off");
  chk_wake_source: assert property (@(posedge clk_sys) disable iff (srst) // R5
    wake_event |-> $past(cyclic_wake_select) != cwt_pkg::SEL_OFF) else $error("wake while disabled");
endmodule : cwt_ctrl

// ### cwt_mcu.sv
// partner: controller model issuing register frames to the wake timer block
`timescale 1ns/1ns
module cwt_mcu (
  // clock
  input wire logic clk_sys,
  // register frames
  output logic reg_wr,
  output logic reg_rd,
  output logic [6:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rd_valid
);
  // ==========================================
  // frame tasks
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 16'h0000;
  end

  task wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = (a == cwt_pkg::ADDR_MASK) ? (d & 16'hFFF3) : d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask : wr

  task rd(input logic [6:0] a, output logic [15:0] d);
    int n;
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = 'x;
    n = 0;
    while (reg_rd_valid !== 1'b1 && n < 4) begin
      @(negedge clk_sys);
      n++;
    end
    if (reg_rd_valid === 1'b1) begin
      d = reg_rdata;
    end
  endtask : rd

  // selector first, on-time second
  task arm(input logic [15:0] v);
    wr(cwt_pkg::ADDR_TIMER, v & 16'h1F8F);
    wr(cwt_pkg::ADDR_TIMER, v);
  endtask : arm
endmodule : cwt_mcu

// ### cwt_tb.sv
// testbench: registers, interrupt pin and cyclic timers of the wake timer block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module testbench;
  // ==========================================
  // signals
  localparam int TK = 10;
  localparam int TMO = 60000;
  localparam int MB[6] = '{6, 5, 5, 4, 1, 0};
  localparam int ON_T[8] = '{0, 1, 3, 10, 100, 200, 0, 0};
  localparam int PER_T[8] = '{100, 200, 500, 1000, 2000, 5000, 10000, 20000};
  logic clk_sys, srst, reg_wr, reg_rd, reg_rd_valid, soft_rst, restart, hw_timer_load;
  logic [6:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, hw_timer_value;
  logic [5:0] ev;
  logic irq_pending, devmode, wake_in, irq_out_n, wake_event, wake_hit, watchdog_run;
  logic [2:0] wake_input_filter_select;
  logic [1:0] timer_active;
  logic [31:0] lf = 32'h72A2CEDB;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;

  // ==========================================
  // instances
  cwt_ctrl #(.TICK_CYCLES(TK), .FILT_CYCLES(16)) uut (.clk_sys(clk_sys), .srst(srst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .soft_rst(soft_rst), .restart(restart), .hw_timer_load(hw_timer_load),
    .hw_timer_value(hw_timer_value), .wd_fail_devmode(ev[0]), .spi_fail(ev[1]), .crc_fail(ev[2]),
    .bridge_stat_set(ev[3]), .temp_stat_set(ev[4]), .supply_stat_set(ev[5]), .irq_pending(irq_pending),
    .devmode(devmode), .wake_input_filter_select(wake_input_filter_select), .wake_in(wake_in),
    .irq_out_n(irq_out_n), .wake_event(wake_event), .wake_hit(wake_hit), .timer_active(timer_active),
    .watchdog_run(watchdog_run));
  cwt_mcu mcu (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid));

  // ==========================================
  // helpers
  always #5 clk_sys = ~clk_sys;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task give_verdict();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == TMO) begin
      error_cnt++;
      give_verdict();
    end
  end

  task pulse_restart();
    @(negedge clk_sys);
    restart = 1'b1;
    @(negedge clk_sys);
    restart = 1'b0;
  endtask : pulse_restart

  // event on source i, optional second event at rt, lows counted over 250 cycles
  task fire(input int i, input logic en, input int rt, input int ex);
    int c;
    int k;
    mcu.wr(cwt_pkg::ADDR_MASK, en ? (16'h0001 << MB[i]) : (16'h00F3 & ~(16'h0001 << MB[i])));
    c = 0;
    for (k = 0; k < 250; k++) begin
      ev = (k == 0 || (rt != 0 && k == rt)) ? 6'(1 << i) : 6'h00;
      if (irq_out_n === 1'b0) c++;
      @(negedge clk_sys);
    end
    `CHK("irq low cycles", ex, c)
  endtask : fire

  task count_falls(input int n, output int c);
    logic p;
    p = irq_out_n;
    c = 0;
    repeat (n) begin
      @(negedge clk_sys);
      if (p === 1'b1 && irq_out_n === 1'b0) c++;
      p = irq_out_n;
    end
  endtask : count_falls

  task nowake(input logic [15:0] v, input logic direct);
    int c;
    pulse_restart();
    if (direct) mcu.wr(cwt_pkg::ADDR_TIMER, v);
    else mcu.arm(v);
    c = 0;
    repeat (1500) begin
      @(negedge clk_sys);
      if (wake_event === 1'b1) c++;
    end
    `CHK("no wake", 0, c)
  endtask : nowake

  task meas(input int i, input int per, input int on);
    int n;
    int a;
    int h;
    n = 0;
    // skip the arming wake, its first tick phase is free
    repeat (2) begin
      @(negedge clk_sys);
      while (wake_event !== 1'b1 && n < 2500) begin
        @(negedge clk_sys);
        n++;
      end
    end
    n = 0;
    a = 0;
    h = 0;
    do begin
      @(negedge clk_sys);
      n++;
      if (timer_active[i] === 1'b1) a++;
      if (wake_hit === 1'b1) h++;
    end while (wake_event !== 1'b1 && n < 5000);
    `CHK("period", per, n)
    `CHK("on time", on, a)
    `CHK("filter hit", 1, h)
  endtask : meas

  // ==========================================
  // main sequence
  initial begin
    logic [15:0] d;
    int i;
    int c;
    clk_sys = 1'b0;
    srst = 1'b1;
    {soft_rst, restart, hw_timer_load, irq_pending, devmode, wake_in} = 6'h00;
    hw_timer_value = 16'h0000;
    ev = 6'h00;
    wake_input_filter_select = 3'h0;
    repeat (12) @(negedge clk_sys);
    srst = 1'b0;
    mcu.rd(cwt_pkg::ADDR_TIMER, d);
    `CHK("timer reset", 16'h0000, d)
    mcu.rd(cwt_pkg::ADDR_MASK, d);
    `CHK("mask reset", 16'h0140, d)
    mcu.wr(7'h07, 16'hFFFF);
    mcu.rd(7'h07, d);
    `CHK("unmapped", 16'h0000, d)
    for (i = 0; i < 8; i++) begin
      lf = lfsr_next(lf);
      mcu.wr(cwt_pkg::ADDR_TIMER, lf[15:0]);
      mcu.rd(cwt_pkg::ADDR_TIMER, d);
      `CHK("timer rw", lf[15:0] & 16'hEFF7, d)
      mcu.wr(cwt_pkg::ADDR_MASK, lf[31:16]);
      mcu.rd(cwt_pkg::ADDR_MASK, d);
      `CHK("mask rw", lf[31:16] & 16'h01F3, d)
    end
    lf = lfsr_next(lf);
    @(negedge clk_sys);
    hw_timer_value = lf[15:0];
    hw_timer_load = 1'b1;
    @(negedge clk_sys);
    hw_timer_load = 1'b0;
    mcu.rd(cwt_pkg::ADDR_TIMER, d);
    `CHK("hw update", lf[15:0] & 16'hEFF7, d)
    mcu.wr(cwt_pkg::ADDR_MASK, 16'h0033);
    pulse_restart();
    mcu.rd(cwt_pkg::ADDR_TIMER, d);
    `CHK("restart timer", 16'h0000, d)
    mcu.rd(cwt_pkg::ADDR_MASK, d);
    `CHK("restart mask", 16'h0033, d)
    mcu.wr(cwt_pkg::ADDR_TIMER, 16'h1234);
    @(negedge clk_sys);
    soft_rst = 1'b1;
    @(negedge clk_sys);
    soft_rst = 1'b0;
    mcu.rd(cwt_pkg::ADDR_TIMER, d);
    `CHK("soft timer", 16'h0000, d)
    mcu.rd(cwt_pkg::ADDR_MASK, d);
    `CHK("soft mask", 16'h0140, d)
    devmode = 1'b1;
    mcu.wr(cwt_pkg::ADDR_MASK, 16'h0080);
    repeat (3) @(negedge clk_sys);
    `CHK("wd off", 1'b0, watchdog_run)
    mcu.wr(cwt_pkg::ADDR_MASK, 16'h0000);
    repeat (3) @(negedge clk_sys);
    `CHK("wd on", 1'b1, watchdog_run)
    for (i = 0; i < 6; i++) begin
      fire(i, 1'b1, 0, 100);
      fire(i, 1'b0, 0, 0);
    end
    fire(4, 1'b1, 50, 150);
    irq_pending = 1'b1;
    mcu.wr(cwt_pkg::ADDR_MASK, 16'h0100);
    repeat (1100) @(negedge clk_sys);
    count_falls(2000, c);
    `CHK("repeat on", 2, c)
    mcu.wr(cwt_pkg::ADDR_MASK, 16'h0000);
    repeat (150) @(negedge clk_sys);
    count_falls(2000, c);
    `CHK("repeat off", 0, c)
    irq_pending = 1'b0;
    nowake(16'h00A0, 1'b1);
    nowake(16'h01A0, 1'b0);
    nowake(16'h00E0, 1'b0);
    wake_in = 1'b1;
    wake_input_filter_select = 3'h2;
    pulse_restart();
    mcu.arm(16'h00A0);
    meas(0, PER_T[0] * TK, ON_T[2] * TK);
    mcu.arm(16'h00B1);
    meas(0, PER_T[1] * TK, ON_T[3] * TK);
    wake_input_filter_select = 3'h3;
    pulse_restart();
    mcu.arm(16'h2100);
    meas(1, PER_T[0] * TK, ON_T[1] * TK);
    give_verdict();
  end
endmodule : testbench
